// ==== lcp_host_vram_panel.sv ====
module lcp_host_vram_panel
    import lcp_pkg::*;
#(
    parameter int LINE_GROUPS = 40,
    parameter int FRAME_LINES = 240
)
(
    input  logic        clk,
    input  logic        reset_n,
    input  logic [15:0] hostDataIn,
    output logic [15:0] hostDataOut,
    output logic        hostDataOe,
    input  logic [15:0] hostAddressBus,
    input  logic        highByteEnableN,
    input  logic        registerSelectN,
    input  logic        registerWriteN,
    input  logic        registerReadN,
    input  logic        vramSelectN,
    input  logic        hostVramWriteN,
    input  logic        hostVramReadN,
    input  logic        hostClock,
    input  logic        hostReset,
    input  logic        busWidthSelect,
    output logic        hostReady,
    input  logic        sram32kMode,
    input  logic        dualPanel,
    input  logic        panel8Bit,
    output logic [12:0] vramAddrBus,
    output logic [2:0]  vramUpperAddr,
    output logic [4:0]  vramChipSelect,
    input  logic [15:0] vramDataIn,
    output logic [15:0] vramDataOut,
    output logic [1:0]  vramDataOe,
    output logic        vramWriteStrobeN,
    output logic [3:0]  upperPanelData,
    output logic [3:0]  lowerPanelData,
    output logic        pixelShiftClock,
    output logic        lineLatchPulse,
    output logic        frameStartPulse,
    output logic        frameAcSignal,
    output logic        panelPowerEnable
);
    localparam int LINE_TOTAL = FRAME_LINES + RETRACE_LINES;

    logic [SYNC_W-1:0] pinRaw;
    logic [SYNC_W-1:0] syncA_q;
    logic [SYNC_W-1:0] syncB_q;
    logic [SYNC_W-1:0] syncC_q;
    logic [SYNC_W-1:0] filt_q;
    logic              selActPrev_q;
    logic              hclkPrev_q;
    logic              selAct;
    logic              selFall;
    logic              hclkRise;
    logic              busWide;
    logic              resetReq;
    logic [15:0]       hAddr;
    logic [15:0]       hData;
    lcp_host_state_t   state_q;
    lcp_cmd_t          cmd_q;
    lcp_cmd_t          cmdNow;
    logic [7:0]        regFile_q [16];
    logic              hostRdPend_q;
    logic              hostRdDone_q;
    logic [15:0]       hostRdWord_q;
    logic              fifoInValid;
    logic              fifoInReady;
    logic [FIFO_W-1:0] fifoInData;
    logic              fifoOutValid;
    logic              fifoOutReady;
    logic [FIFO_W-1:0] fifoOutData;
    lcp_op_t           opKind_q;
    logic [1:0]        opCnt_q;
    logic [15:0]       opAddr_q;
    logic              takeU;
    logic              takeL;
    logic              takeH;
    logic [1:0]        dispPend_q;
    logic [15:0]       dispAddr_q;
    logic [15:0]       fetchAddr_q;
    logic [7:0]        fetchU_q;
    logic [7:0]        fetchL_q;
    logic [7:0]        showU_q;
    logic [7:0]        showL_q;
    logic [7:0]        divCnt_q;
    logic              nibSel_q;
    logic              inLatch_q;
    logic [15:0]       grpCnt_q;
    logic [15:0]       lineCnt_q;
    logic              tick;
    logic              lastGrp;
    logic              lastLine;
    logic              fetchReq;
    logic              showOn;
    logic [15:0]       reqAddr;
    logic [15:0]       step;

    // Chip select lines and shared upper address lines
    function automatic logic [7:0] chipDecode(input logic [15:0] a, input logic big);
        logic [7:0] sel;
        sel = 8'hFF;
        if (big)
        begin
            sel = {1'b1, a[14], a[13], 3'h7, ~a[15], a[15]};
        end
        else
        begin
            sel[a[15:13]] = 1'b0;
        end
        return sel;
    endfunction

    // Pixel nibbles per panel mode, upper then lower
    function automatic logic [7:0] panelNib(input logic [7:0] u, input logic [7:0] l,
                                            input logic nib, input logic dual, input logic wide);
        logic [7:0] r;
        r = 8'h00;
        if (dual)
        begin
            r = nib ? {u[3:0], l[3:0]} : {u[7:4], l[7:4]};
        end
        else if (wide)
        begin
            r = nib ? l : u;
        end
        else
        begin
            r = nib ? {u[3:0], 4'h0} : {u[7:4], 4'h0};
        end
        return r;
    endfunction

    function automatic lcp_cmd_t decodeCmd(input logic [5:0] c);
        lcp_cmd_t k;
        k = CMD_ERROR;
        if (c[5] && c[2])
        begin
            k = CMD_NONE;
        end
        else
        begin
            case (c)
                6'h0F:   k = CMD_REG_WR;
                6'h17:   k = CMD_REG_RD;
                6'h39:   k = CMD_MEM_WR;
                6'h3A:   k = CMD_MEM_RD;
                default: k = CMD_ERROR;
            endcase
        end
        return k;
    endfunction

    assign pinRaw = {busWidthSelect, hostReset, hostClock, highByteEnableN, registerSelectN,
                     registerWriteN, registerReadN, vramSelectN, hostVramWriteN, hostVramReadN,
                     hostAddressBus, hostDataIn};

    // Pin synchroniser and agreement filter
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            syncA_q <= SYNC_RESET;
            syncB_q <= SYNC_RESET;
            syncC_q <= SYNC_RESET;
            filt_q  <= SYNC_RESET;
        end
        else
        begin
            syncA_q <= pinRaw;
            syncB_q <= syncA_q;
            syncC_q <= syncB_q;
            filt_q  <= (~(syncB_q ^ syncC_q) & syncC_q) | ((syncB_q ^ syncC_q) & filt_q);
        end
    end

    assign hData    = filt_q[15:0];
    assign hAddr    = filt_q[SB_ADDR+15:SB_ADDR];
    assign selAct   = !filt_q[SB_CTRL+5] || !filt_q[SB_CTRL+2];
    assign selFall  = selAct && !selActPrev_q;
    assign hclkRise = filt_q[SB_HCLK] && !hclkPrev_q;
    assign resetReq = filt_q[SB_HRESET];
    assign busWide  = filt_q[SB_WIDTH];
    assign cmdNow   = decodeCmd(filt_q[SB_CTRL+5:SB_CTRL]);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            selActPrev_q <= 1'b0;
            hclkPrev_q   <= 1'b0;
        end
        else
        begin
            selActPrev_q <= selAct;
            hclkPrev_q   <= filt_q[SB_HCLK];
        end
    end

    // Host access sequencer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q   <= HS_IDLE;
            cmd_q     <= CMD_NONE;
            hostReady <= 1'b1;
        end
        else
        begin
            case (state_q)
                HS_IDLE:
                begin
                    if (selFall)
                    begin
                        hostReady <= 1'b0;
                        state_q   <= HS_DECODE;
                    end
                end
                HS_DECODE:
                begin
                    cmd_q   <= cmdNow;
                    state_q <= (cmdNow == CMD_MEM_WR || cmdNow == CMD_MEM_RD) ? HS_SERVE
                                                                              : HS_RELEASE;
                end
                HS_SERVE:
                begin
                    if ((cmd_q == CMD_MEM_WR && fifoInReady) || hostRdDone_q)
                    begin
                        state_q <= HS_RELEASE;
                    end
                end
                HS_RELEASE:
                begin
                    if (hclkRise)
                    begin
                        hostReady <= 1'b1;
                        state_q   <= HS_FINISH;
                    end
                end
                HS_FINISH:
                begin
                    if (!selAct)
                    begin
                        state_q <= HS_IDLE;
                    end
                end
                default:
                begin
                    state_q   <= HS_IDLE;
                    hostReady <= 1'b1;
                end
            endcase
        end
    end

    // Control registers and read-back drive
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 16; i++)
            begin
                regFile_q[i] <= REG_RESET;
            end
            hostDataOut <= 16'h0000;
            hostDataOe  <= 1'b0;
        end
        else
        begin
            if (resetReq)
            begin
                for (int i = 0; i < 16; i++)
                begin
                    regFile_q[i] <= REG_RESET;
                end
            end
            else if (state_q == HS_DECODE && cmdNow == CMD_REG_WR)
            begin
                regFile_q[hAddr[REG_IDX_W-1:0]] <= (busWide && hAddr[0]) ? hData[15:8]
                                                                         : hData[7:0];
            end
            if (state_q == HS_DECODE && cmdNow == CMD_REG_RD)
            begin
                hostDataOut <= {2{regFile_q[hAddr[REG_IDX_W-1:0]]}};
                hostDataOe  <= 1'b1;
            end
            else if (state_q == HS_SERVE && hostRdDone_q)
            begin
                hostDataOut <= hostRdWord_q;
                hostDataOe  <= 1'b1;
            end
            else if (state_q == HS_FINISH && !selAct)
            begin
                hostDataOe <= 1'b0;
            end
        end
    end

    // lane mask and lane data for writes
    assign fifoInValid = state_q == HS_SERVE && cmd_q == CMD_MEM_WR;
    assign fifoInData  = !busWide ? {2'b01, hAddr, 8'hFF, hData[7:0]}
                       : hAddr[0] ? {2'b10, hAddr, hData[15:8], 8'hFF}
                       : {!filt_q[SB_HBE], 1'b1, hAddr, hData};

    lcp_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) writeFifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoInData),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // Display fetch first, then host read, then buffered writes
    always_comb
    begin
        takeU        = opCnt_q == 2'h0 && dispPend_q[0];
        takeL        = opCnt_q == 2'h0 && !dispPend_q[0] && dispPend_q[1];
        takeH        = opCnt_q == 2'h0 && dispPend_q == 2'h0 && hostRdPend_q;
        fifoOutReady = opCnt_q == 2'h0 && dispPend_q == 2'h0 && !hostRdPend_q;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hostRdPend_q <= 1'b0;
            dispPend_q   <= 2'h0;
        end
        else
        begin
            hostRdPend_q <= (hostRdPend_q && !takeH)
                         || (state_q == HS_DECODE && cmdNow == CMD_MEM_RD);
            dispPend_q   <= (dispPend_q & ~{takeL, takeU}) | {2{fetchReq}};
        end
    end

    // VRAM cycle engine
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            opKind_q         <= OP_IDLE;
            opCnt_q          <= 2'h0;
            opAddr_q         <= 16'h0000;
            vramAddrBus      <= 13'h0000;
            vramUpperAddr    <= 3'h7;
            vramChipSelect   <= 5'h1F;
            vramDataOut      <= 16'h0000;
            vramDataOe       <= 2'h0;
            vramWriteStrobeN <= 1'b1;
            fetchU_q         <= 8'h00;
            fetchL_q         <= 8'h00;
            hostRdWord_q     <= 16'h0000;
            hostRdDone_q     <= 1'b0;
        end
        else
        begin
            hostRdDone_q <= 1'b0;
            if (opCnt_q == 2'h0)
            begin
                opKind_q <= OP_IDLE;
                if (takeU || takeL || takeH || (fifoOutValid && fifoOutReady))
                begin
                    opAddr_q <= takeU ? fetchAddr_q
                              : takeL ? fetchAddr_q + (dualPanel ? LOWER_BASE : 16'h0001)
                              : takeH ? hAddr : fifoOutData[31:16];
                    opKind_q <= takeU ? OP_DISP_U : takeL ? OP_DISP_L
                              : takeH ? OP_HOST_RD : OP_FIFO_WR;
                    opCnt_q  <= 2'h1;
                    if (!takeU && !takeL && !takeH)
                    begin
                        vramDataOut <= fifoOutData[15:0];
                        vramDataOe  <= fifoOutData[33:32];
                    end
                end
                else
                begin
                    vramChipSelect <= 5'h1F;
                    vramUpperAddr  <= sram32kMode ? vramUpperAddr : 3'h7;
                end
            end
            else
            begin
                opCnt_q <= (opCnt_q == OP_LAST) ? 2'h0 : opCnt_q + 2'h1;
            end
            if (opCnt_q == 2'h1)
            begin
                vramAddrBus    <= opAddr_q[12:0];
                {vramUpperAddr, vramChipSelect} <= chipDecode(opAddr_q, sram32kMode);
                vramWriteStrobeN <= opKind_q != OP_FIFO_WR;
            end
            if (opCnt_q == 2'h2)
            begin
                vramWriteStrobeN <= 1'b1;
                if (opKind_q == OP_DISP_U)
                begin
                    fetchU_q <= (busWide && opAddr_q[0]) ? vramDataIn[15:8] : vramDataIn[7:0];
                end
                if (opKind_q == OP_DISP_L)
                begin
                    fetchL_q <= (busWide && opAddr_q[0]) ? vramDataIn[15:8] : vramDataIn[7:0];
                end
                if (opKind_q == OP_HOST_RD)
                begin
                    hostRdWord_q <= busWide ? vramDataIn : {2{vramDataIn[7:0]}};
                    hostRdDone_q <= 1'b1;
                end
            end
            if (opCnt_q == OP_LAST)
            begin
                vramDataOe <= 2'h0;
            end
        end
    end

    // Panel scan timing
    assign tick     = divCnt_q == 8'(SHIFT_DIV - 1);
    assign lastGrp  = grpCnt_q == 16'(LINE_GROUPS - 1);
    assign lastLine = lineCnt_q == 16'(LINE_TOTAL - 1);
    assign fetchReq = tick && !inLatch_q && (nibSel_q == lastGrp);
    assign showOn   = regFile_q[MODE_REG_IDX][MODE_DISP_BIT] && lineCnt_q < 16'(FRAME_LINES);
    assign step     = (panel8Bit && !dualPanel) ? 16'h0002 : 16'h0001;
    assign reqAddr  = (inLatch_q || !lastGrp || !lastLine) ? dispAddr_q : 16'h0000;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            divCnt_q    <= 8'h00;
            nibSel_q    <= 1'b0;
            inLatch_q   <= 1'b0;
            grpCnt_q    <= 16'h0000;
            lineCnt_q   <= 16'h0000;
            dispAddr_q  <= 16'h0000;
            fetchAddr_q <= 16'h0000;
        end
        else
        begin
            divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
            if (fetchReq)
            begin
                fetchAddr_q <= reqAddr;
                dispAddr_q  <= reqAddr + step;
            end
            if (tick)
            begin
                if (inLatch_q)
                begin
                    inLatch_q <= 1'b0;
                    lineCnt_q <= lastLine ? 16'h0000 : lineCnt_q + 16'h0001;
                end
                else
                begin
                    nibSel_q <= !nibSel_q;
                    if (nibSel_q)
                    begin
                        inLatch_q <= lastGrp;
                        grpCnt_q  <= lastGrp ? 16'h0000 : grpCnt_q + 16'h0001;
                    end
                end
            end
        end
    end

    // Panel pin drive
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            upperPanelData   <= 4'h0;
            lowerPanelData   <= 4'h0;
            showU_q          <= 8'h00;
            showL_q          <= 8'h00;
            pixelShiftClock  <= 1'b0;
            lineLatchPulse   <= 1'b0;
            frameStartPulse  <= 1'b0;
            frameAcSignal    <= 1'b0;
            panelPowerEnable <= 1'b0;
        end
        else
        begin
            panelPowerEnable <= regFile_q[MODE_REG_IDX][MODE_POWER_BIT];
            if (tick)
            begin
                // data changes on shift clock rise
                if (inLatch_q || nibSel_q)
                begin
                    showU_q <= fetchU_q;
                    showL_q <= fetchL_q;
                end
                {upperPanelData, lowerPanelData} <=
                    !showOn || (nibSel_q && lastGrp) ? 8'h00
                    : (inLatch_q || nibSel_q)
                    ? panelNib(fetchU_q, fetchL_q, 1'b0, dualPanel, panel8Bit)
                    : panelNib(showU_q, showL_q, 1'b1, dualPanel, panel8Bit);
                pixelShiftClock <= !(nibSel_q && lastGrp);
                lineLatchPulse  <= nibSel_q && lastGrp;
                // frame start on last retrace line
                if (nibSel_q && lastGrp && lastLine)
                begin
                    frameStartPulse <= 1'b1;
                end
                if (inLatch_q && lastLine)
                begin
                    frameAcSignal <= !frameAcSignal;
                end
            end
            else if (divCnt_q == 8'(SHIFT_HALF - 1))
            begin
                pixelShiftClock <= 1'b0;
                if (!inLatch_q)
                begin
                    frameStartPulse <= 1'b0;
                end
            end
        end
    end
endmodule

// ==== lcp_pkg.sv ====
// Functional notes
// - Low four address bits pick register
// - Host address passes straight to VRAM
// - Select falling edge pulls wait low
// - Wait released on host clock rise
// - Width strap: low 8-bit, high 16-bit
// - Active-high reset clears control registers
// - Decode the six select/strobe inputs
// - 16-bit bus: even bytes low lane, odd high; 8-bit bus: all low lane
// - Chip selects decode 8K or 32K SRAMs
// - Write strobe pulses on every VRAM write
// - Dual panel nibbles, single uses eight with panel8Bit, else four
// - Panel data stable at shift clock fall
// - Line latch pulse after each line
// - Frame start pulse, two retrace lines
// - Panel power follows mode bit 1
package lcp_pkg;
    localparam int             REG_IDX_W      = 4;
    localparam logic [3:0]     MODE_REG_IDX   = 4'h1;
    localparam int             MODE_DISP_BIT  = 0;
    localparam int             MODE_POWER_BIT = 1;
    localparam logic [7:0]     REG_RESET      = 8'h00;
    localparam int             SYNC_W         = 42;
    localparam int             SB_ADDR        = 16;
    localparam int             SB_CTRL        = 32;
    localparam int             SB_HBE         = 38;
    localparam int             SB_HCLK        = 39;
    localparam int             SB_HRESET      = 40;
    localparam int             SB_WIDTH       = 41;
    localparam logic [41:0]    SYNC_RESET     = 42'h07F_0000_0000;
    localparam int             CLK_PERIOD_NS  = 10;
    localparam int             SHIFT_NS       = 160;
    localparam int             SHIFT_DIV      = (SHIFT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int             SHIFT_HALF     = SHIFT_DIV / 2;
    localparam int             RETRACE_LINES  = 2;
    localparam logic [1:0]     OP_LAST        = 2'h3;
    localparam logic [15:0]    LOWER_BASE     = 16'h4000;
    localparam int             FIFO_W         = 34;
    localparam int             FIFO_DEPTH     = 8;

    typedef enum logic [2:0]
    {
        HS_IDLE    = 3'b000,
        HS_DECODE  = 3'b001,
        HS_SERVE   = 3'b011,
        HS_RELEASE = 3'b010,
        HS_FINISH  = 3'b110
    } lcp_host_state_t;

    typedef enum logic [2:0]
    {
        CMD_NONE,
        CMD_REG_WR,
        CMD_REG_RD,
        CMD_MEM_WR,
        CMD_MEM_RD,
        CMD_ERROR
    } lcp_cmd_t;

    typedef enum logic [2:0]
    {
        OP_IDLE,
        OP_DISP_U,
        OP_DISP_L,
        OP_HOST_RD,
        OP_FIFO_WR
    } lcp_op_t;
endpackage

// ==== lcp_fifo.sv ====
module lcp_fifo
    import lcp_pkg::*;
#(
    parameter int WIDTH = FIFO_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  logic             clk,
    input  logic             reset_n,
    input  logic             inValid,
    output logic             inReady,
    input  logic [WIDTH-1:0] inData,
    output logic             outValid,
    input  logic             outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      rdPtr_q;

    // Full when pointers differ only in wrap bit
    assign inReady  = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData  = mem_q[rdPtr_q[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (inValid && inReady)
        begin
            mem_q[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end
        else
        begin
            if (inValid && inReady)
            begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (outValid && outReady)
            begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule

// ==== lcp_host_vram_panel_checker.sv ====
module lcp_host_vram_panel_checker (
    input logic       clk,
    input logic       reset_n,
    input logic       registerSelectN,
    input logic       vramSelectN,
    input logic       hostClock,
    input logic       hostReset,
    input logic       hostReady,
    input logic [2:0] vramUpperAddr,
    input logic [4:0] vramChipSelect,
    input logic       vramWriteStrobeN,
    input logic [3:0] upperPanelData,
    input logic [3:0] lowerPanelData,
    input logic       pixelShiftClock,
    input logic       lineLatchPulse,
    input logic       frameStartPulse,
    input logic       frameAcSignal,
    input logic       panelPowerEnable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence selFall;
        $fell(registerSelectN & vramSelectN) && hostReady;
    endsequence
    sequence waitOn;
        ##[2:7] !hostReady;
    endsequence
    wait_low_a: assert property (selFall |-> waitOn)
        else $error("wait missing after select");
    ready_rise_a: assert property ($rose(hostReady) |-> $past(hostClock, 2))
        else $error("ready rose off host clock");
    strobe_pulse_a: assert property ($fell(vramWriteStrobeN) |=> vramWriteStrobeN)
        else $error("write strobe not one cycle");
    strobe_sel_a: assert property (!vramWriteStrobeN |-> {vramUpperAddr, vramChipSelect} != 8'hFF)
        else $error("write without chip select");
    latch_shift_a: assert property (lineLatchPulse |-> !pixelShiftClock)
        else $error("shift during latch");
    data_hold_a: assert property ($fell(pixelShiftClock) |->
        $stable({upperPanelData, lowerPanelData}))
        else $error("panel data moved at fall");
    frame_ac_a: assert property ($changed(frameAcSignal) |-> frameStartPulse)
        else $error("ac toggle outside frame start");
    power_off_a: assert property ($rose(hostReset) |-> ##[3:7] !panelPowerEnable)
        else $error("power stayed on in reset");
endmodule
bind lcp_host_vram_panel lcp_host_vram_panel_checker CHK (.*);

// ==== lcp_sram_model.sv ====
module lcp_sram_model (
    input  logic        clk,
    input  logic [12:0] addr,
    input  logic [2:0]  upper,
    input  logic [4:0]  cs,
    input  logic [15:0] wdata,
    input  logic [1:0]  oe,
    input  logic        weN,
    output logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:262143];
    logic        tick = 1'b0;
    wire  [17:0] key = {cs[1:0], upper, addr};
    wire         sel = ({upper, cs} != 8'hFF);
    always @(posedge clk)
    begin
        tick <= ~tick;
        if (!weN && sel && oe[0]) mem[key][7:0] <= wdata[7:0];
        if (!weN && sel && oe[1]) mem[key][15:8] <= wdata[15:8];
    end
    // Unselected bus shows a moving pattern
    assign rdata = sel ? mem[key] : {16{tick}} ^ 16'h5A5A;
endmodule

// ==== lcp_host_vram_panel_tb.sv ====
module lcp_host_vram_panel_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LG = 4;
    localparam int FL = 4;
    logic [15:0] hostAddressBus = '0, busData = '0, hostDataOut, vramDataIn, vramDataOut, r;
    logic [15:0] ad [4] = '{16'h0000, 16'h2002, 16'h8006, 16'hE004};
    logic [12:0] vramAddrBus;
    logic [4:0]  vramChipSelect;
    logic [3:0]  upperPanelData, lowerPanelData;
    logic [2:0]  vramUpperAddr;
    logic [1:0]  vramDataOe;
    logic        clk = 0, reset_n = 0, hostClock = 0, hostReset = 0, v;
    logic        registerSelectN = 1, registerWriteN = 1, registerReadN = 1;
    logic        vramSelectN = 1, hostVramWriteN = 1, hostVramReadN = 1, highByteEnableN = 0;
    logic        busWidthSelect = 1, sram32kMode = 0, dualPanel = 1, panel8Bit = 0;
    logic        hostDataOe, hostReady, vramWriteStrobeN, pixelShiftClock, lineLatchPulse;
    logic        frameStartPulse, frameAcSignal, panelPowerEnable;
    int          err_total = 0, cmp_count = 0, n;
    wire  [15:0] hostDataIn = hostDataOe ? hostDataOut
                            : {busWidthSelect ? busData[15:8] : 8'hFF, busData[7:0]};
    initial forever #5 clk = ~clk;
    initial forever #62.5 hostClock = ~hostClock;
    lcp_host_vram_panel #(.LINE_GROUPS(LG), .FRAME_LINES(FL)) DUT (.*);
    lcp_sram_model SRAM (.clk, .addr(vramAddrBus), .upper(vramUpperAddr), .cs(vramChipSelect),
        .wdata(vramDataOut), .oe(vramDataOe), .weN(vramWriteStrobeN), .rdata(vramDataIn));
    task automatic chk(input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [5:0] p, input logic [15:0] a, d, output logic [15:0] q);
        @(posedge clk);
        {registerWriteN, registerReadN, hostVramWriteN, hostVramReadN} <= {p[4:3], p[1:0]};
        hostAddressBus <= a;
        busData <= d;
        repeat (4) @(posedge clk);
        {registerSelectN, vramSelectN} <= {p[5], p[2]};
        for (n = 0; n < 300 && hostReady !== 1'b0; n++) @(negedge clk);
        chk(n == 300, 0);
        for (n = 0; n < 300 && hostReady !== 1'b1; n++) @(negedge clk);
        chk(n == 300, 0);
        q = hostDataOut;
        @(posedge clk);
        {registerSelectN, vramSelectN, registerWriteN, registerReadN} <= '1;
        {hostVramWriteN, hostVramReadN} <= '1;
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #200us;
        err_total++;
        end_of_test();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        reset_n <= 1;
        @(negedge clk);
        chk(hostReady, 1);
        chk(vramChipSelect, 5'h1F);
        chk(panelPowerEnable, 0);
        $display("test reset done");
        acc(6'b001111, 16'h00F1, 16'h0303, r);
        repeat (3) @(negedge clk);
        chk(panelPowerEnable, 1);
        acc(6'b010111, 16'h0001, 0, r);
        chk(r, 16'h0303);
        acc(6'b001111, 16'h0011, 16'h0101, r);
        repeat (3) @(negedge clk);
        chk(panelPowerEnable, 0);
        acc(6'b001111, 16'h0001, 16'h0303, r);
        $display("test registers done");
        for (int m = 0; m < 2; m++)
        begin
            sram32kMode <= m[0];
            foreach (ad[i]) acc(6'b111001, ad[i], ad[i] ^ 16'h5A5A, r);
            foreach (ad[i])
            begin
                acc(6'b111010, ad[i], 0, r);
                chk(r, ad[i] ^ 16'h5A5A);
            end
        end
        acc(6'b010111, 16'h0001, 0, r);
        chk(r, 16'h0303);
        acc(6'b111010, 16'h0000, 0, r);
        chk(r, 16'h5A5A);
        {busWidthSelect, highByteEnableN} <= 2'b01;
        acc(6'b111001, 16'h0003, 16'h003C, r);
        acc(6'b111010, 16'h0003, 0, r);
        chk(r, 16'h3C3C);
        {busWidthSelect, highByteEnableN} <= 2'b10;
        $display("test vram done");
        repeat (2)
        begin
            v = frameAcSignal;
            for (n = 0; n < 2000 && frameAcSignal === v; n++) @(negedge clk);
        end
        chk(n[15:0], (FL + 2) * (2 * LG + 1) * lcp_pkg::SHIFT_DIV);
        $display("test frame done");
        @(posedge clk);
        hostReset <= 1;
        repeat (9) @(negedge clk);
        chk(panelPowerEnable, 0);
        @(posedge clk);
        hostReset <= 0;
        $display("test host reset done");
        end_of_test();
    end
endmodule
